// *** sram_consts.svh ***
// Widths, depth, pin-group bit positions and reset values of the synchronous 16K x 16 memory.
// Assumes it is included by bare name from the package and the design modules.
`ifndef SRAM_CONSTS_SVH
`define SRAM_CONSTS_SVH

// ----------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------
`define SRAM_ADDR_W 14
`define SRAM_DEPTH 16384
`define SRAM_DATA_W 16
`define SRAM_BYTE_W 8
`define SRAM_LANES 2

// ----------------------------------------------------------------
// Byte lane positions on the shared data pins
// ----------------------------------------------------------------
`define SRAM_LANE_LOW 0
`define SRAM_LANE_HIGH 1

// ----------------------------------------------------------------
// Bits of the chip select pair
// ----------------------------------------------------------------
`define SRAM_CS_ACT_HIGH_BIT 0
`define SRAM_CS_ACT_LOW_BIT 1
`define SRAM_CS_W 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SRAM_ADDR_RST 14'h0000
`define SRAM_DATA_RST 16'h0000

`endif

// *** sram_pkg.sv ***
// Types shared by the synchronous memory top and its lane array.
// Assumes sram_consts.svh is on the include path.
`include "sram_consts.svh"

package sram_pkg;

  // ----------------------------------------------------------------
  // Cycle kinds decided from the registered controls
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CYCLE_DESEL = 3'h1,
    CYCLE_READ = 3'h2,
    CYCLE_WRITE = 3'h4
  } cycle_kind_e;

  // ----------------------------------------------------------------
  // State of the top: registered cycle, address and input latch
  // ----------------------------------------------------------------
  typedef struct packed {
    cycle_kind_e cycle;
    logic [`SRAM_ADDR_W-1:0] addr;
    logic [`SRAM_DATA_W-1:0] latch_hold;
  } state_s;

  // ----------------------------------------------------------------
  // State of the lane array: the registered read word
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`SRAM_DATA_W-1:0] rd_data;
  } rd_state_s;

endpackage

// *** sram_lane_array.sv ***
// Byte-lane storage of the 16K x 16 array with one write port and one registered read port.
// Assumes the caller gives lane enables, address and data that are stable at the rising edge.
`include "sram_consts.svh"

module sram_lane_array (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [`SRAM_LANES-1:0] wr_lane_en,
  input wire logic [`SRAM_ADDR_W-1:0] wr_addr,
  input wire logic [`SRAM_DATA_W-1:0] wr_data,
  input wire logic [`SRAM_ADDR_W-1:0] rd_addr,
  output logic [`SRAM_DATA_W-1:0] rd_data
);

  sram_pkg::rd_state_s state_ff;
  sram_pkg::rd_state_s nxt_state;
  logic [`SRAM_DATA_W-1:0] rd_next;

  // ----------------------------------------------------------------
  // Per-lane storage
  // ----------------------------------------------------------------
  // Each lane owns its own array so that a byte write never touches the
  // other lane, and no array has two writers.
  for (genvar g = 0; g < `SRAM_LANES; g++) begin : g_lane
    logic [`SRAM_BYTE_W-1:0] cell_ff [`SRAM_DEPTH];
    logic bypass;

    always_ff @(posedge sys_clk) begin
      if (wr_lane_en[g]) begin
        cell_ff[wr_addr] <= wr_data[g*`SRAM_BYTE_W +: `SRAM_BYTE_W];
      end
    end

    // A write and a read of the same word at one edge return the new byte.
    assign bypass = wr_lane_en[g] && (wr_addr == rd_addr);
    assign rd_next[g*`SRAM_BYTE_W +: `SRAM_BYTE_W] =
      bypass ? wr_data[g*`SRAM_BYTE_W +: `SRAM_BYTE_W] : cell_ff[rd_addr];
  end

  // ----------------------------------------------------------------
  // Registered read word
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_state.rd_data = rd_next;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '{rd_data: `SRAM_DATA_RST};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rd_data = state_ff.rd_data;

endmodule // sram_lane_array

// *** sync_sram_16k_x16_late_write.sv ***
// Synchronous 16K x 16 static memory with registered controls, byte strobes and a data-in latch.
// Assumes the controller runs on sys_clk, so its outputs arrive without synchronisers,
// and that the bench resolves the shared data wire from shared_data_oe_n.

`include "sram_consts.svh"

module sync_sram_16k_x16_late_write (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [`SRAM_ADDR_W-1:0] word_address_in,
  input wire logic [`SRAM_CS_W-1:0] chip_select_pair,
  input wire logic sync_write_request_n,
  input wire logic low_byte_strobe_n,
  input wire logic high_byte_strobe_n,
  input wire logic output_enable_n,
  input wire logic data_latch_open,
  input wire logic [`SRAM_DATA_W-1:0] shared_data_in,
  output logic [`SRAM_DATA_W-1:0] shared_data_out,
  output logic shared_data_oe_n
);

  sram_pkg::state_s state_ff;
  sram_pkg::state_s nxt_state;

  logic selected;
  logic [`SRAM_DATA_W-1:0] latch_view;
  logic [`SRAM_LANES-1:0] strobe_lanes;
  logic [`SRAM_LANES-1:0] wr_lane_en;
  logic drive_read;
  logic [`SRAM_DATA_W-1:0] rd_word;

  // ----------------------------------------------------------------
  // Select decode and strobe lanes
  // ----------------------------------------------------------------
  // Selection needs the active-high select high and the active-low one low.
  assign selected = chip_select_pair[`SRAM_CS_ACT_HIGH_BIT] && !chip_select_pair[`SRAM_CS_ACT_LOW_BIT];

  // Lane 0 is pins 1 to 8, lane 1 is pins 9 to 16.
  assign strobe_lanes[`SRAM_LANE_LOW] = !low_byte_strobe_n;
  assign strobe_lanes[`SRAM_LANE_HIGH] = !high_byte_strobe_n;

  // ----------------------------------------------------------------
  // Data-in latch
  // ----------------------------------------------------------------
  // The latch is modelled on sys_clk: while open, pin data passes straight
  // through; once closed, the value last seen while open is held. Data that
  // changes between two edges with the latch open is not seen, a limit of
  // modelling an asynchronous latch on a single clock.
  assign latch_view = data_latch_open ? shared_data_in : state_ff.latch_hold;

  // ----------------------------------------------------------------
  // Cycle decode from the registered controls
  // ----------------------------------------------------------------
  always_comb begin
    wr_lane_en = '0;
    drive_read = 1'b0;
    unique case (state_ff.cycle)
      sram_pkg::CYCLE_DESEL: begin
        wr_lane_en = '0;
        drive_read = 1'b0;
      end
      sram_pkg::CYCLE_READ: begin
        wr_lane_en = '0;
        drive_read = !output_enable_n;
      end
      sram_pkg::CYCLE_WRITE: begin
        // Both strobes high leaves the lanes off, which aborts the late write.
        wr_lane_en = strobe_lanes;
        drive_read = 1'b0;
      end
      default: begin
        wr_lane_en = '0;
        drive_read = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_state.addr = word_address_in;
    nxt_state.latch_hold = latch_view;
    if (!selected) begin
      nxt_state.cycle = sram_pkg::CYCLE_DESEL;
    end else if (sync_write_request_n) begin
      nxt_state.cycle = sram_pkg::CYCLE_READ;
    end else begin
      nxt_state.cycle = sram_pkg::CYCLE_WRITE;
    end
  end

  // Reset parks the block in a deselected cycle, so the pins float until
  // a selected read has been registered.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '{cycle: sram_pkg::CYCLE_DESEL, addr: `SRAM_ADDR_RST, latch_hold: `SRAM_DATA_RST};
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // The read port looks up the address now on the pins, so the word is in
  // its flip-flops for the whole cycle that this edge begins.
  sram_lane_array u_array (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wr_lane_en(wr_lane_en),
    .wr_addr(state_ff.addr),
    .wr_data(latch_view),
    .rd_addr(word_address_in),
    .rd_data(rd_word)
  );

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // The output enable is an asynchronous gate and acts in the same cycle.
  assign shared_data_out = rd_word;
  assign shared_data_oe_n = !drive_read;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  addr_capture_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n) |-> state_ff.addr == $past(word_address_in)
  ) else $error("Registered address does not follow the address pins.");

  cycle_kind_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    selected && !sync_write_request_n |=> state_ff.cycle == sram_pkg::CYCLE_WRITE
  ) else $error("Selected low write request did not start a write cycle.");

  read_request_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    selected && sync_write_request_n |=> state_ff.cycle == sram_pkg::CYCLE_READ && wr_lane_en == '0
  ) else $error("High write request did not start a read cycle.");

  deselect_float_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !selected |=> shared_data_oe_n && wr_lane_en == '0
  ) else $error("Deselected cycle drove pins or wrote memory.");

  read_drive_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    selected && sync_write_request_n ##1 !output_enable_n |-> !shared_data_oe_n
  ) else $error("Selected read with output enable low left the pins floating.");

  read_gate_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    output_enable_n |-> shared_data_oe_n
  ) else $error("Pins driven while output enable is high.");

  lane_split_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $past(selected && !sync_write_request_n) && $past(rst_n)
    |-> wr_lane_en == {!high_byte_strobe_n, !low_byte_strobe_n}
  ) else $error("Byte lanes do not follow their strobes in a write cycle.");

  late_abort_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    low_byte_strobe_n && high_byte_strobe_n |-> wr_lane_en == '0
  ) else $error("Write with both strobes high was not aborted.");

  word_write_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $past(selected && !sync_write_request_n) && $past(rst_n) && !low_byte_strobe_n && !high_byte_strobe_n
    |-> wr_lane_en == 2'h3 && shared_data_oe_n
  ) else $error("Word write did not enable both lanes or drove the pins.");

  write_target_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wr_lane_en != '0 |-> $past(selected && !sync_write_request_n) && u_array.wr_addr == $past(word_address_in)
  ) else $error("Write committed outside a write cycle or at the wrong address.");

  latch_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $past(data_latch_open) && !data_latch_open && $past(rst_n) |-> latch_view == $past(shared_data_in)
  ) else $error("Closed latch did not hold the data seen while open.");

  latched_write_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !data_latch_open && $past(!data_latch_open) && $past(rst_n) |-> latch_view == $past(latch_view)
  ) else $error("Latch content changed while the latch was closed.");

  transparent_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    data_latch_open |-> u_array.wr_data == shared_data_in
  ) else $error("Open latch did not pass pin data to the array.");

  reset_float_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) |-> shared_data_oe_n ##1 ($past(selected && sync_write_request_n) || shared_data_oe_n)
  ) else $error("Pins driven before a selected read was registered after reset.");

  // ----------------------------------------------------------------
  // Checks: cycle decode
  // ----------------------------------------------------------------
  // Apart from the two strobe gates, these look at the registered cycle itself, so a broken decode is
  // caught even where the pins happen to show the right level.
  desel_cycle_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !selected |=> state_ff.cycle == sram_pkg::CYCLE_DESEL
  ) else $error("Deselect request did not register a deselected cycle.");

  cycle_onehot_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $onehot(state_ff.cycle)
  ) else $error("Registered cycle kind is not a single legal code.");

  write_only_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    state_ff.cycle != sram_pkg::CYCLE_WRITE |-> wr_lane_en == '0
  ) else $error("Array written outside a write cycle.");

  write_no_drive_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    state_ff.cycle == sram_pkg::CYCLE_WRITE |-> shared_data_oe_n
  ) else $error("Pins driven during a write cycle.");

  oe_follow_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    state_ff.cycle == sram_pkg::CYCLE_READ |-> shared_data_oe_n == output_enable_n
  ) else $error("Read drive does not follow the output enable.");

  abort_float_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    state_ff.cycle == sram_pkg::CYCLE_WRITE && low_byte_strobe_n && high_byte_strobe_n
    |-> shared_data_oe_n && wr_lane_en == '0
  ) else $error("Aborted write drove the pins or wrote the array.");

  low_strobe_gate_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wr_lane_en[`SRAM_LANE_LOW] |-> !low_byte_strobe_n
  ) else $error("Lower byte written without its strobe.");

  high_strobe_gate_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wr_lane_en[`SRAM_LANE_HIGH] |-> !high_byte_strobe_n
  ) else $error("Upper byte written without its strobe.");

  // ----------------------------------------------------------------
  // Checks: latch and array
  // ----------------------------------------------------------------
  latch_update_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n) |-> state_ff.latch_hold == $past(latch_view)
  ) else $error("Latch copy did not take the latch view of the last edge.");

  transparent_store_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    state_ff.cycle == sram_pkg::CYCLE_WRITE && data_latch_open |-> u_array.wr_data == shared_data_in
  ) else $error("Transparent write did not store the pin data.");

  latched_store_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    state_ff.cycle == sram_pkg::CYCLE_WRITE && !data_latch_open && $past(data_latch_open) && $past(rst_n)
    |-> u_array.wr_data == $past(shared_data_in)
  ) else $error("Latched write did not store the data caught at the latch close.");

  // A write and a read of the same word at one edge must hand the new bytes
  // to the read register; the lane bypass is what makes this true.
  write_bypass_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wr_lane_en == 2'h3 && u_array.rd_addr == u_array.wr_addr |=> shared_data_out == $past(latch_view)
  ) else $error("Word written at the read address did not reach the read register.");

  low_lane_write_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wr_lane_en == 2'h1 && u_array.rd_addr == u_array.wr_addr
    |=> shared_data_out[`SRAM_BYTE_W-1:0] == $past(latch_view[`SRAM_BYTE_W-1:0])
  ) else $error("Lower byte write did not land on pins 1 to 8.");

  high_lane_write_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wr_lane_en == 2'h2 && u_array.rd_addr == u_array.wr_addr
    |=> shared_data_out[`SRAM_DATA_W-1:`SRAM_BYTE_W] == $past(latch_view[`SRAM_DATA_W-1:`SRAM_BYTE_W])
  ) else $error("Upper byte write did not land on pins 9 to 16.");

  // ----------------------------------------------------------------
  // Checks: reset
  // ----------------------------------------------------------------
  // This one has no disable clause on purpose: it must hold while reset
  // is still asserted, which stands in for the power-up window.
  reset_park_a: assert property (
    @(posedge sys_clk)
    !rst_n |-> shared_data_oe_n && wr_lane_en == '0
  ) else $error("Pins driven or array written while reset is held.");

endmodule // sync_sram_16k_x16_late_write

// *** sram_ctl_model.sv ***
// Controller model that drives the registered and asynchronous inputs of the memory.
// Assumes the bench resolves the shared data wire and calls the two cycle tasks.
`include "sram_consts.svh"

module sram_ctl_model (
  input wire logic sys_clk,
  input wire logic [`SRAM_DATA_W-1:0] pin_level,
  input wire logic shared_data_oe_n,
  output logic [`SRAM_ADDR_W-1:0] word_address_in,
  output logic [`SRAM_CS_W-1:0] chip_select_pair,
  output logic sync_write_request_n,
  output logic low_byte_strobe_n,
  output logic high_byte_strobe_n,
  output logic output_enable_n,
  output logic data_latch_open,
  output logic [`SRAM_DATA_W-1:0] ctl_data
);
  timeunit 1ns;
  timeprecision 1ps;

  logic drive = 1'b0;
  logic [`SRAM_DATA_W-1:0] wdata = 16'h0000;
  logic [`SRAM_DATA_W-1:0] idle_pat = 16'h5a5a;

  initial begin
    word_address_in <= 14'h0000;
    chip_select_pair <= 2'b00;
    sync_write_request_n <= 1'b1;
    low_byte_strobe_n <= 1'b1;
    high_byte_strobe_n <= 1'b1;
    output_enable_n <= 1'b0;
    data_latch_open <= 1'b1;
  end

  // A released wire has no pull, so it shows a pattern that flips every cycle.
  always @(posedge sys_clk) idle_pat <= ~idle_pat;
  assign ctl_data = drive ? wdata : idle_pat;

  task automatic read_cycle(input logic [1:0] cs, input logic [13:0] addr, input logic oe_n,
                            output logic [15:0] got, output logic got_oe_n);
    @(posedge sys_clk);
    word_address_in <= addr;
    chip_select_pair <= cs;
    sync_write_request_n <= 1'b1;
    output_enable_n <= oe_n;
    @(posedge sys_clk);
    chip_select_pair <= 2'b00;
    @(negedge sys_clk);
    got = pin_level;
    got_oe_n = shared_data_oe_n;
  endtask

  task automatic write_cycle(input logic [1:0] cs, input logic [13:0] addr, input logic [15:0] data,
                             input logic lo_n, input logic hi_n, input logic latched, output logic got_oe_n);
    @(posedge sys_clk);
    word_address_in <= addr;
    chip_select_pair <= cs;
    sync_write_request_n <= 1'b0;
    low_byte_strobe_n <= lo_n;
    high_byte_strobe_n <= hi_n;
    wdata <= data;
    drive <= 1'b1;
    @(posedge sys_clk);
    chip_select_pair <= 2'b00;
    sync_write_request_n <= 1'b1;
    if (latched) begin
      data_latch_open <= 1'b0;
      wdata <= ~data;
    end
    @(negedge sys_clk);
    got_oe_n = shared_data_oe_n;
    @(posedge sys_clk);
    low_byte_strobe_n <= 1'b1;
    high_byte_strobe_n <= 1'b1;
    data_latch_open <= 1'b1;
    drive <= 1'b0;
    @(negedge sys_clk);
  endtask
endmodule // sram_ctl_model

// *** sync_sram_16k_x16_late_write_bench.sv ***
// Self-checking bench of the synchronous 16K x 16 memory, driven through the controller model.
// Assumes the design files and sram_ctl_model.sv are compiled first.
`include "sram_consts.svh"

module sync_sram_16k_x16_late_write_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  int failures = 0;
  int checked = 0;
  logic [`SRAM_ADDR_W-1:0] addr;
  logic [`SRAM_CS_W-1:0] cs;
  logic wr_n, lo_n, hi_n, oe_n, latch;
  logic [`SRAM_DATA_W-1:0] dout, ctl_data, pin_level, got;
  logic dut_oe_n, got_oe_n;

  always #5 sys_clk = ~sys_clk;
  // Whoever has the wire: the memory when its enable is low, else the controller.
  assign pin_level = (dut_oe_n === 1'b0) ? dout : ctl_data;

  sync_sram_16k_x16_late_write u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .word_address_in(addr),
    .chip_select_pair(cs), .sync_write_request_n(wr_n), .low_byte_strobe_n(lo_n),
    .high_byte_strobe_n(hi_n), .output_enable_n(oe_n), .data_latch_open(latch),
    .shared_data_in(pin_level), .shared_data_out(dout), .shared_data_oe_n(dut_oe_n));

  sram_ctl_model u_ctl (.sys_clk(sys_clk), .pin_level(pin_level), .shared_data_oe_n(dut_oe_n),
    .word_address_in(addr), .chip_select_pair(cs), .sync_write_request_n(wr_n),
    .low_byte_strobe_n(lo_n), .high_byte_strobe_n(hi_n), .output_enable_n(oe_n),
    .data_latch_open(latch), .ctl_data(ctl_data));

  task automatic check_word(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("FAIL %0t word %h expected %h", $time, g, e);
    end
  endtask

  task automatic check_bit(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("FAIL %0t drive enable %b expected %b", $time, g, e);
    end
  endtask

  task automatic close_out;
    if (failures == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic t_power_up;
    repeat (5) @(negedge sys_clk);
    check_bit(dut_oe_n, 1'b1);
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(negedge sys_clk);
    check_bit(dut_oe_n, 1'b1);
  endtask

  task automatic t_word(input logic lat, input logic [13:0] a, input logic [15:0] d);
    u_ctl.write_cycle(2'b01, a, d, 1'b0, 1'b0, lat, got_oe_n);
    check_bit(got_oe_n, 1'b1);
    u_ctl.read_cycle(2'b01, a, 1'b0, got, got_oe_n);
    check_word(got, d);
    check_bit(got_oe_n, 1'b0);
  endtask

  task automatic t_bytes;
    u_ctl.write_cycle(2'b01, 14'h0000, 16'h1234, 1'b0, 1'b0, 1'b0, got_oe_n);
    u_ctl.write_cycle(2'b01, 14'h0000, 16'hffab, 1'b0, 1'b1, 1'b0, got_oe_n);
    u_ctl.read_cycle(2'b01, 14'h0000, 1'b0, got, got_oe_n);
    check_word(got, 16'h12ab);
    u_ctl.write_cycle(2'b01, 14'h0000, 16'hcd99, 1'b1, 1'b0, 1'b1, got_oe_n);
    u_ctl.read_cycle(2'b01, 14'h0000, 1'b0, got, got_oe_n);
    check_word(got, 16'hcdab);
  endtask

  task automatic t_abort;
    u_ctl.write_cycle(2'b01, 14'h0000, 16'h0f0f, 1'b1, 1'b1, 1'b0, got_oe_n);
    check_bit(got_oe_n, 1'b1);
    u_ctl.read_cycle(2'b01, 14'h0000, 1'b0, got, got_oe_n);
    check_word(got, 16'hcdab);
  endtask

  task automatic t_deselect;
    logic [1:0] cs_tab [3] = '{2'b00, 2'b10, 2'b11};
    for (int i = 0; i < 3; i++) begin
      u_ctl.write_cycle(cs_tab[i], 14'h3fff, 16'h0000, 1'b0, 1'b0, 1'b0, got_oe_n);
      u_ctl.read_cycle(cs_tab[i], 14'h3fff, 1'b0, got, got_oe_n);
      check_bit(got_oe_n, 1'b1);
    end
    u_ctl.read_cycle(2'b01, 14'h3fff, 1'b0, got, got_oe_n);
    check_word(got, 16'ha5c3);
  endtask

  task automatic t_oe_gate;
    u_ctl.read_cycle(2'b01, 14'h2aaa, 1'b1, got, got_oe_n);
    check_bit(got_oe_n, 1'b1);
  endtask

  // Under two hundred cycles are needed; the limit leaves ample margin.
  initial begin
    #20000;
    failures++;
    close_out;
  end

  initial begin
    t_power_up;
    t_word(1'b0, 14'h3fff, 16'ha5c3);
    t_bytes;
    t_abort;
    t_word(1'b1, 14'h2aaa, 16'h5a3c);
    t_deselect;
    t_oe_gate;
    close_out;
  end
endmodule // sync_sram_16k_x16_late_write_bench
